/* File: hdl/ctm_map.svh */
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH
// Counter widths of the two variants.
`define CTM_WIDTH_32   32
`define CTM_WIDTH_16   16
// Channel counts.
`define CTM_NMATCH     4
`define CTM_NCAP       2
// Positions of the sticky event flags.
`define CTM_FLAG_MATCH0 0
`define CTM_FLAG_CAP0   4
`define CTM_NFLAG       6
// Match output actions.
`define CTM_ACT_NONE   2'h0
`define CTM_ACT_LOW    2'h1
`define CTM_ACT_HIGH   2'h2
`define CTM_ACT_TOGGLE 2'h3
// Reset values.
`define CTM_MOUT_RST   4'h0
`define CTM_FLAG_RST   6'h00
`endif

/* File: hdl/ctm_pkg.sv */
package ctm_pkg;
  // Run state of the counter.
  typedef enum logic [1:0]
  {
    CTM_IDLE = 2'b00,
    CTM_RUN  = 2'b01,
    CTM_HALT = 2'b10
  } ctm_state_t;
endpackage

/* File: hdl/ctm_cap_if.sv */
`timescale 1ns/10ps
`include "ctm_map.svh"
// Carries the count to the capture unit and its events and values back.
interface ctm_cap_if #(parameter int W = `CTM_WIDTH_32);
  logic [W-1:0]               count;
  logic [`CTM_NCAP-1:0]        riseEv;
  logic [`CTM_NCAP-1:0]        fallEv;
  logic [`CTM_NCAP-1:0]        capEv;
  logic [`CTM_NCAP-1:0][W-1:0] capVal;
  modport timer (output count, input riseEv, fallEv, capEv, capVal);
  modport cap   (input count, output riseEv, fallEv, capEv, capVal);
endinterface

/* File: hdl/ctm_capture.sv */
`timescale 1ns/10ps
`include "ctm_map.svh"
module ctm_capture #(parameter int W = `CTM_WIDTH_32)
(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 clkEn,
  input  wire logic [`CTM_NCAP-1:0] capPin,
  input  wire logic [`CTM_NCAP-1:0] capRiseEn,
  input  wire logic [`CTM_NCAP-1:0] capFallEn,
  ctm_cap_if.cap                    capIf
);
  // ==========================================================
  // Per-channel edge detection and snapshot.
  logic [`CTM_NCAP-1:0] pinPrev_r;

  // Remembers the last pin level to find transitions.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pinPrev_r <= '0;
    else if (clkEn)
      pinPrev_r <= capPin;
  end

  for (genvar i = 0; i < `CTM_NCAP; i++)
  begin : g_ch
    // Edges qualify only while the clock enable lets state move.
    assign capIf.riseEv[i] = clkEn && capPin[i] && !pinPrev_r[i];
    assign capIf.fallEv[i] = clkEn && !capPin[i] && pinPrev_r[i];
    assign capIf.capEv[i]  = (capIf.riseEv[i] && capRiseEn[i])
                          || (capIf.fallEv[i] && capFallEn[i]);

    // Copies the running count when the selected edge arrives.
    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
        capIf.capVal[i] <= '0;
      else if (capIf.capEv[i])
        capIf.capVal[i] <= capIf.count; // see [RL5]
    end

    a_cap_snapshot: assert property ( // see [RL5]
      @(posedge clk) disable iff (!reset_n)
      capIf.capEv[i] |=> capIf.capVal[i] == $past(capIf.count))
      else $error("Capture value does not hold the count at the edge.");
  end
endmodule

/* File: hdl/ctm_timer.sv */
// Function
// [RL1] Counter and prescaler share one width, 32 or 16 bits.
// [RL2] Two 32-bit and two 16-bit instances behave alike except width.
// [RL3] Timer operation counts system clock cycles scaled by the prescaler.
// [RL4] Software selects timer operation or counting external input edges.
// [RL5] Two capture channels copy the count on an input transition.
// [RL6] Each capture channel may raise an interrupt request.
// [RL7] Four match values are compared against the running count.
// [RL8] A match may let counting continue, optionally interrupting.
// [RL9] A match may halt the counter, optionally interrupting.
// [RL10] A match may return the counter to zero, optionally interrupting.
// [RL11] Four match outputs go low, high, toggle or stay on a match.
// [RL12] A selected capture event may clear counter and prescaler.
// [RL13] Prescaler wraps at its programmed value and advances the counter.
// [RL14] Events set sticky flags; interrupts only for enabled flags.
`timescale 1ns/10ps
`include "ctm_map.svh"
module ctm_timer #(parameter int W = `CTM_WIDTH_32) // see [RL1] [RL2]
(
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          clkEn,
  input  wire logic                          timerEn,
  input  wire logic                          swReset,
  input  wire logic                          countMode,
  input  wire logic                          countRise,
  input  wire logic                          countPin,
  input  wire logic [W-1:0]                  prescaleMax,
  input  wire logic [`CTM_NMATCH-1:0][W-1:0] matchVal,
  input  wire logic [`CTM_NMATCH-1:0]        matchIntEn,
  input  wire logic [`CTM_NMATCH-1:0]        matchResetEn,
  input  wire logic [`CTM_NMATCH-1:0]        matchStopEn,
  input  wire logic [`CTM_NMATCH-1:0][1:0]   matchAction,
  input  wire logic [`CTM_NCAP-1:0]          capPin,
  input  wire logic [`CTM_NCAP-1:0]          capRiseEn,
  input  wire logic [`CTM_NCAP-1:0]          capFallEn,
  input  wire logic [`CTM_NCAP-1:0]          capIntEn,
  input  wire logic                          clrOnCapEn,
  input  wire logic                          clrCapChan,
  input  wire logic                          clrCapRise,
  input  wire logic [`CTM_NFLAG-1:0]         flagClear,
  output logic      [W-1:0]                  count_r,
  output logic      [W-1:0]                  prescale_r,
  output logic      [`CTM_NCAP-1:0][W-1:0]   capVal_r,
  output logic      [`CTM_NMATCH-1:0]        matchOut_r,
  output logic      [`CTM_NFLAG-1:0]         flags_r,
  output logic                               irq_r,
  output logic                               running_r
);
  // ==========================================================
  // Capture unit.
  ctm_cap_if #(.W(W)) capIf ();
  ctm_pkg::ctm_state_t        state_r;
  ctm_pkg::ctm_state_t        state_nxt;
  logic                       run;
  logic                       pinPrev_r;
  logic                       pinEdge;
  logic                       preWrap;
  logic                       tick;
  logic                       clrHit;
  logic [`CTM_NMATCH-1:0]     matchHit;
  logic [`CTM_NFLAG-1:0]      events;
  logic [`CTM_NFLAG-1:0]      intEn;
  logic [W-1:0]               count_nxt;
  // Reset levels of the match outputs, one bit per channel.
  localparam logic [`CTM_NMATCH-1:0] MOUT_RST = `CTM_MOUT_RST;

  assign capIf.count = count_r;
  assign capVal_r    = capIf.capVal;

  ctm_capture #(.W(W)) u_capture
  (
    .clk       (clk),
    .reset_n   (reset_n),
    .clkEn     (clkEn),
    .capPin    (capPin),
    .capRiseEn (capRiseEn),
    .capFallEn (capFallEn),
    .capIf     (capIf)
  );

  // ==========================================================
  // Count sources and events.
  assign run     = state_r == ctm_pkg::CTM_RUN;
  assign pinEdge = countRise ? (countPin && !pinPrev_r)
                             : (!countPin && pinPrev_r);
  assign preWrap = prescale_r == prescaleMax;
  // Timer mode paces on the prescaler, counter mode on pin edges.
  assign tick    = clkEn && run
                && (countMode ? pinEdge : preWrap); // see [RL3] [RL4]
  assign clrHit  = clrOnCapEn && (clrCapRise ? capIf.riseEv[clrCapChan]
                                             : capIf.fallEv[clrCapChan]);

  // Each comparator fires when the count equals its value on a tick.
  for (genvar i = 0; i < `CTM_NMATCH; i++)
  begin : g_cmp
    assign matchHit[i] = tick && count_r == matchVal[i]; // see [RL7]
  end

  assign events = {capIf.capEv, matchHit};
  assign intEn  = {capIntEn, matchIntEn}; // see [RL6]

  // Remembers the count pin level for edge detection.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pinPrev_r <= 1'b0;
    else if (clkEn)
      pinPrev_r <= countPin;
  end

  // ==========================================================
  // Run state: a stop match halts until the enable is dropped.
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ctm_pkg::CTM_IDLE:
        if (timerEn)
          state_nxt = ctm_pkg::CTM_RUN;
      ctm_pkg::CTM_RUN:
        if (!timerEn)
          state_nxt = ctm_pkg::CTM_IDLE;
        else if (|(matchHit & matchStopEn))
          state_nxt = ctm_pkg::CTM_HALT; // see [RL9]
      ctm_pkg::CTM_HALT:
        if (!timerEn)
          state_nxt = ctm_pkg::CTM_IDLE;
      default:
        state_nxt = ctm_pkg::CTM_IDLE;
    endcase
  end

  // Holds the run state and its visible copy.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r   <= ctm_pkg::CTM_IDLE;
      running_r <= 1'b0;
    end
    else if (clkEn)
    begin
      state_r   <= state_nxt;
      running_r <= state_nxt == ctm_pkg::CTM_RUN;
    end
  end

  // ==========================================================
  // Prescaler: counts clock cycles and wraps at its programmed value.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prescale_r <= '0;
    else if (clkEn)
    begin
      if (swReset || clrHit)
        prescale_r <= '0; // see [RL12]
      else if (run && !countMode)
        prescale_r <= preWrap ? '0 : W'(prescale_r + 1'b1); // see [RL13]
    end
  end

  // Next count: clear wins, then match reset, then stop, then advance.
  always_comb
  begin
    count_nxt = count_r;
    if (swReset || clrHit)
      count_nxt = '0; // see [RL12]
    else if (|(matchHit & matchResetEn))
      count_nxt = '0; // see [RL10]
    else if (|(matchHit & matchStopEn))
      count_nxt = count_r; // see [RL9]
    else if (tick)
      count_nxt = W'(count_r + 1'b1); // see [RL8] [RL13]
  end

  // Holds the running count.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count_r <= '0;
    else if (clkEn)
      count_r <= count_nxt;
  end

  // ==========================================================
  // Match outputs follow their configured action.
  for (genvar i = 0; i < `CTM_NMATCH; i++)
  begin : g_mout
    always_ff @(posedge clk or negedge reset_n)
    begin
      if (!reset_n)
        matchOut_r[i] <= MOUT_RST[i];
      else if (matchHit[i])
      begin
        case (matchAction[i])
          `CTM_ACT_LOW:    matchOut_r[i] <= 1'b0; // see [RL11]
          `CTM_ACT_HIGH:   matchOut_r[i] <= 1'b1; // see [RL11]
          `CTM_ACT_TOGGLE: matchOut_r[i] <= !matchOut_r[i]; // see [RL11]
          default:         matchOut_r[i] <= matchOut_r[i];
        endcase
      end
    end
  end

  // ==========================================================
  // Sticky flags: a new event wins over a clear in the same cycle.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      flags_r <= `CTM_FLAG_RST;
    else if (clkEn)
      flags_r <= (flags_r & ~flagClear) | events; // see [RL14]
  end

  // Interrupt request from enabled flags only.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_r <= 1'b0;
    else if (clkEn)
      irq_r <= |(((flags_r & ~flagClear) | events) & intEn); // see [RL14]
  end

  // ==========================================================
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_timerWrap;
    clkEn && run && !countMode && preWrap && !swReset && !clrHit;
  endsequence

  sequence s_plainTick;
    tick && !swReset && !clrHit && !(|(matchHit & (matchResetEn
      | matchStopEn)));
  endsequence

  a_prescale_wrap: assert property ( // see [RL13]
    s_timerWrap |=> prescale_r == '0)
    else $error("Prescaler did not wrap at its programmed value.");

  a_count_step: assert property ( // see [RL3] [RL8]
    s_plainTick |=> count_r == W'($past(count_r) + 1'b1))
    else $error("Count did not advance by one on a tick.");

  a_counter_mode: assert property ( // see [RL4]
    clkEn && run && countMode && !pinEdge && !swReset && !clrHit
    |=> count_r == $past(count_r))
    else $error("Count moved in counter mode without a pin edge.");

  a_match_reset: assert property ( // see [RL10]
    |(matchHit & matchResetEn) && !swReset && !clrHit |=> count_r == '0)
    else $error("Reset match did not clear the count.");

  a_match_stop: assert property ( // see [RL9]
    |(matchHit & matchStopEn) && timerEn
    |=> !running_r ##0 state_r == ctm_pkg::CTM_HALT)
    else $error("Stop match did not halt the counter.");

  a_capture_clear: assert property ( // see [RL12]
    clkEn && clrHit |=> count_r == '0 && prescale_r == '0)
    else $error("Capture clear left counter or prescaler nonzero.");

  a_flag_sticky: assert property ( // see [RL14]
    clkEn && |events |=> (flags_r & $past(events)) == $past(events))
    else $error("Event flag was not set.");

  a_irq_gate: assert property ( // see [RL6] [RL14]
    clkEn && !(|(((flags_r & ~flagClear) | events) & intEn)) |=> !irq_r)
    else $error("Interrupt raised with no enabled flag.");

  a_out_high: assert property ( // see [RL11]
    matchHit[0] && matchAction[0] == `CTM_ACT_HIGH |=> matchOut_r[0])
    else $error("Match output did not go high.");

  a_out_toggle: assert property ( // see [RL11]
    matchHit[1] && matchAction[1] == `CTM_ACT_TOGGLE
    |=> matchOut_r[1] != $past(matchOut_r[1]))
    else $error("Match output did not toggle.");
endmodule

/* File: tb/ctm_pin_model.sv */
`timescale 1ns/10ps
// ==========================================================================
// External pins: capture inputs and count input, idle low.
module ctm_pin_model
(
  input  wire logic       clk,
  input  wire logic [3:0] matchOut,
  output logic      [1:0] capPin,
  output logic            countPin
);
  // Pins start low; every change lands on a falling edge.
  initial
  begin
    capPin   = 2'h0;
    countPin = 1'b0;
  end
  // Holds one capture line high for n cycles, a pulse to be measured.
  task automatic capPulse(input int ch, input int n);
    @(negedge clk);
    capPin[ch] = 1'b1;
    repeat (n) @(negedge clk);
    capPin[ch] = 1'b0;
  endtask
  // Gives the count input n pulses, two cycles high and two low.
  task automatic countPulses(input int n);
    repeat (n)
    begin
      @(negedge clk);
      countPin = 1'b1;
      repeat (2) @(negedge clk);
      countPin = 1'b0;
      @(negedge clk);
    end
  endtask
endmodule

/* File: tb/ctm_timer_tb.sv */
`timescale 1ns/10ps
// ==========================================================================
// Self-checking bench for the 16-bit counter variant.
module ctm_timer_tb;
  typedef struct packed {
    logic [1:0] ch;
    logic [1:0] act;
    logic       rst;
    logic       stp;
    logic       ie;
    logic       out;
  } ctm_row_t;
  localparam int W = 16;
  logic                clk;
  logic                reset_n;
  logic                clkEn;
  logic                timerEn;
  logic                swReset;
  logic                countMode;
  logic                countRise;
  logic                countPin;
  logic [W-1:0]        prescaleMax;
  logic [3:0][W-1:0]   matchVal;
  logic [3:0]          matchIntEn;
  logic [3:0]          matchResetEn;
  logic [3:0]          matchStopEn;
  logic [3:0][1:0]     matchAction;
  logic [1:0]          capPin;
  logic [1:0]          capRiseEn;
  logic [1:0]          capFallEn;
  logic [1:0]          capIntEn;
  logic                clrOnCapEn;
  logic                clrCapChan;
  logic                clrCapRise;
  logic [5:0]          flagClear;
  logic [W-1:0]        count_r;
  logic [W-1:0]        prescale_r;
  logic [1:0][W-1:0]   capVal_r;
  logic [3:0]          matchOut_r;
  logic [5:0]          flags_r;
  logic                irq_r;
  logic                running_r;
  int                  failures;
  int                  nCompared;
  int                  k;
  int                  c;
  int                  expCount;
  // Match rows: channel, action, reset, stop, irq enable, output after.
  ctm_row_t rows [7] = '{'{2'h0, 2'h2, 1'b0, 1'b0, 1'b1, 1'b1},
                         '{2'h0, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0},
                         '{2'h1, 2'h3, 1'b0, 1'b1, 1'b1, 1'b1},
                         '{2'h1, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0},
                         '{2'h2, 2'h2, 1'b1, 1'b0, 1'b1, 1'b1},
                         '{2'h3, 2'h3, 1'b0, 1'b1, 1'b0, 1'b1},
                         '{2'h2, 2'h0, 1'b0, 1'b0, 1'b1, 1'b1}};
  ctm_timer #(.W(W)) u_ctm_timer (.clk(clk), .reset_n(reset_n),
    .clkEn(clkEn), .timerEn(timerEn), .swReset(swReset),
    .countMode(countMode), .countRise(countRise), .countPin(countPin),
    .prescaleMax(prescaleMax), .matchVal(matchVal),
    .matchIntEn(matchIntEn), .matchResetEn(matchResetEn),
    .matchStopEn(matchStopEn), .matchAction(matchAction),
    .capPin(capPin), .capRiseEn(capRiseEn), .capFallEn(capFallEn),
    .capIntEn(capIntEn), .clrOnCapEn(clrOnCapEn),
    .clrCapChan(clrCapChan), .clrCapRise(clrCapRise),
    .flagClear(flagClear), .count_r(count_r), .prescale_r(prescale_r),
    .capVal_r(capVal_r), .matchOut_r(matchOut_r), .flags_r(flags_r),
    .irq_r(irq_r), .running_r(running_r));
  ctm_pin_model u_ctm_pin_model (.clk(clk), .matchOut(matchOut_r),
    .capPin(capPin), .countPin(countPin));
  // The 40 MHz clock.
  always #12.5 clk = ~clk;
  // Compares one value and counts the outcome.
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("compared %0d mismatched %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Zeros count and flags, then lets the counter run again.
  task automatic restart();
    timerEn   = 1'b0;
    swReset   = 1'b1;
    flagClear = 6'h3f;
    @(negedge clk);
    swReset   = 1'b0;
    flagClear = 6'h00;
    timerEn   = 1'b1;
  endtask
  // Waits, bounded, for a flag to rise.
  task automatic waitFlag(input int f);
    int n;
    n = 0;
    while (flags_r[f] !== 1'b1 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    if (flags_r[f] !== 1'b1)
    begin
      failures++;
      end_sim();
    end
  endtask
  // Main sequence.
  initial
  begin
    {clk, reset_n, swReset, countMode, capRiseEn} = 6'h00;
    {capFallEn, capIntEn, clrOnCapEn, clrCapChan, clrCapRise} = 7'h00;
    {matchIntEn, matchResetEn, matchStopEn, flagClear} = 18'h00000;
    countRise   = 1'b0;
    timerEn     = 1'b0;
    failures    = 0;
    nCompared   = 0;
    clkEn       = 1'b1;
    prescaleMax = 16'h0001;
    matchVal    = {4{16'h0040}};
    matchAction = 8'h00;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    check("resetCount", 32'(count_r), 0);
    check("resetOut", 32'(matchOut_r), 0);
    check("resetFlags", 32'(flags_r), 0);
    timerEn = 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    check("walkCount", 32'(count_r), 2);
    check("walkPre", 32'(prescale_r), 0);
    $display("prescale test done");
    for (k = 0; k < 7; k++)
    begin
      c              = rows[k].ch;
      matchVal       = {4{16'h0040}};
      matchVal[c]    = 16'h0003;
      matchAction    = 8'h00;
      matchAction[c] = rows[k].act;
      matchResetEn   = {3'h0, rows[k].rst} << rows[k].ch;
      matchStopEn    = {3'h0, rows[k].stp} << rows[k].ch;
      matchIntEn     = {3'h0, rows[k].ie} << rows[k].ch;
      expCount       = rows[k].rst ? 0 : rows[k].stp ? 3 : 4;
      restart();
      waitFlag(c);
      check("matchOut", 32'(matchOut_r[c]), 32'(rows[k].out));
      check("matchCount", 32'(count_r), expCount);
      if (rows[k].stp)
        check("halted", 32'(running_r), 0);
      @(negedge clk);
      check("matchIrq", 32'(irq_r), 32'(rows[k].ie));
    end
    $display("match table done");
    matchIntEn   = 4'h0;
    matchResetEn = 4'h0;
    matchStopEn  = 4'h0;
    matchVal     = {4{16'h0040}};
    prescaleMax  = 16'h0000;
    {clrOnCapEn, clrCapRise, capRiseEn, capFallEn, capIntEn} = 8'hff;
    restart();
    u_ctm_pin_model.capPulse(0, 5);
    @(negedge clk);
    check("capWidth", 32'(capVal_r[0]), 4);
    check("capFlag", 32'(flags_r[4]), 1);
    @(negedge clk);
    check("capIrq", 32'(irq_r), 1);
    clrOnCapEn = 1'b0;
    capRiseEn  = 2'h2;
    capFallEn  = 2'h0;
    $display("capture test done");
    countMode = 1'b1;
    restart();
    u_ctm_pin_model.countPulses(3);
    check("events", 32'(count_r), 3);
    check("preHeld", 32'(prescale_r), 0);
    // Rising-edge counting adds one for a single pulse.
    countRise = 1'b1;
    u_ctm_pin_model.countPulses(1);
    check("riseEvents", 32'(count_r), 4);
    u_ctm_pin_model.capPulse(1, 1);
    check("capSecond", 32'(capVal_r[1]), 4);
    countMode = 1'b0;
    clkEn     = 1'b0;
    flagClear = 6'h3f;
    repeat (3) @(negedge clk);
    check("frozen", 32'(count_r), 4);
    check("frozenFlags", 32'(flags_r[5]), 1);
    check("frozenIrq", 32'(irq_r), 1);
    clkEn = 1'b1;
    @(negedge clk);
    flagClear = 6'h00;
    @(negedge clk);
    check("cleared", 32'(flags_r), 0);
    check("irqOff", 32'(irq_r), 0);
    $display("counter test done");
    reset_n = 1'b0;
    @(negedge clk);
    check("midReset", 32'({running_r, matchOut_r, count_r}), 0);
    reset_n = 1'b1;
    @(negedge clk);
    check("restarted", 32'(running_r), 1);
    $display("reset test done");
    end_sim();
  end
endmodule
